// ==== rtl/omsr_pkg.sv ====
// package: shared constants and types of the optical motion sensor register bank
package omsr_pkg;
    // clock and timing
    localparam int unsigned CLK_PERIOD_NS = 4;        // 250 MHz system clock
    localparam int unsigned RESYNC_NS     = 1000;     // serial clock idle time that resyncs
    localparam int unsigned RESYNC_CYC    = (RESYNC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LPT_TICK_US   = 1000;     // low power timer tick period
    localparam int unsigned LPT_TICK_CYC  = LPT_TICK_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned WAKE_NS       = 1000;     // wake pulse width on leaving sleep
    localparam int unsigned WAKE_CYC      = WAKE_NS / CLK_PERIOD_NS;

    // register addresses
    localparam logic [6:0] ADDR_ID_UPPER   = 7'h00;
    localparam logic [6:0] ADDR_ID_LOWER   = 7'h01;
    localparam logic [6:0] ADDR_MOVE_FLAGS = 7'h02;
    localparam logic [6:0] ADDR_X_DISP     = 7'h03;
    localparam logic [6:0] ADDR_Y_DISP     = 7'h04;
    localparam logic [6:0] ADDR_POWER_MODE = 7'h05;
    localparam logic [6:0] ADDR_SENSOR_CFG = 7'h06;
    localparam logic [6:0] ADDR_SURF_QUAL  = 7'h07;
    localparam logic [6:0] ADDR_ACTIVITY   = 7'h08;
    localparam logic [6:0] ADDR_WRITE_LOCK = 7'h09;
    localparam logic [6:0] ADDR_LIGHT_CFG  = 7'h0A;
    localparam logic [6:0] ADDR_ENTRY_DLY  = 7'h0B;
    localparam logic [6:0] ADDR_DEEP_CFG   = 7'h0C;
    localparam logic [6:0] ADDR_THRESHOLD  = 7'h0D;
    localparam logic [6:0] ADDR_RECOG_CTRL = 7'h0E;

    // reset values of the writable registers
    localparam logic [7:0] RST_POWER_MODE = 8'hB8;
    localparam logic [7:0] RST_SENSOR_CFG = 8'h04;
    localparam logic [7:0] RST_WRITE_LOCK = 8'h00;
    localparam logic [7:0] RST_LIGHT_CFG  = 8'h72;
    localparam logic [7:0] RST_ENTRY_DLY  = 8'h12;
    localparam logic [7:0] RST_DEEP_CFG   = 8'h92;
    localparam logic [7:0] RST_THRESHOLD  = 8'h0A;
    localparam logic [7:0] RST_RECOG_CTRL = 8'hE5;

    // field positions
    localparam int unsigned CFG_RES_LSB      = 0;     // resolution_select in sensor_config
    localparam int unsigned PMODE_LIGHT_BIT  = 4;     // light sleep enable
    localparam int unsigned PMODE_DEEP_BIT   = 3;     // deep sleep enable
    localparam int unsigned ENTRY_LIGHT_LSB  = 4;     // idle ticks before light sleep
    localparam int unsigned ENTRY_DEEP_LSB   = 0;     // idle ticks before deep sleep
    localparam int unsigned SER_RW_BIT       = 7;     // 1 = write in the address byte

    // serial port state
    typedef enum logic [1:0] {SER_ADDR, SER_WDATA, SER_RLOAD, SER_RDATA} omsr_ser_t;
    // power state
    typedef enum logic [1:0] {PWR_NORMAL, PWR_LIGHT, PWR_DEEP} omsr_pwr_t;

    // one motion report from the estimation engine
    typedef struct packed {
        logic signed [7:0] dx;       // x motion, two's complement
        logic signed [7:0] dy;       // y motion, two's complement
        logic [7:0]        quality;  // image quality of the frame
    } omsr_motion_t;
endpackage

// ==== rtl/omsr_regs.sv ====
// module: register bank, serial port slave and wake logic of the optical motion sensor
`timescale 1ns/1ps
`default_nettype none

module omsr_regs #(
    parameter logic [11:0] PRODUCT_IDENT = 12'hA5C,  // arbitrary value
    parameter logic [3:0]  RSVD_NIBBLE   = 4'h0,     // arbitrary value
    parameter int unsigned LPT_TICK_CYC  = omsr_pkg::LPT_TICK_CYC,
    parameter int unsigned RESYNC_CYC    = omsr_pkg::RESYNC_CYC,
    parameter int unsigned WAKE_CYC      = omsr_pkg::WAKE_CYC
) (
    input  wire logic                   clock,
    input  wire logic                   sys_rst,
    input  wire logic                   sclk,
    input  wire logic                   sdio_i,
    output logic                        sdio_o,
    output logic                        sdio_oe_n,
    output logic                        wake_motion_n,
    input  wire logic                   motion_valid,
    input  wire omsr_pkg::omsr_motion_t motion_sample,
    output logic [2:0]                  resolution_select,
    output logic [7:0]                  recognition_ctrl,
    output logic [7:0]                  light_sleep_cfg,
    output logic [7:0]                  deep_sleep_cfg,
    output logic                        light_sleep,
    output logic                        deep_sleep
);
    localparam int LPT_W  = $clog2(LPT_TICK_CYC + 1);
    localparam int IDLE_W = $clog2(RESYNC_CYC + 1);
    localparam int WAKE_W = $clog2(WAKE_CYC + 1);

    // address decode shared by write path and read multiplexer
    function automatic logic is_writable(input logic [6:0] a);
        case (a)
            omsr_pkg::ADDR_POWER_MODE, omsr_pkg::ADDR_SENSOR_CFG,
            omsr_pkg::ADDR_WRITE_LOCK, omsr_pkg::ADDR_LIGHT_CFG,
            omsr_pkg::ADDR_ENTRY_DLY,  omsr_pkg::ADDR_DEEP_CFG,
            omsr_pkg::ADDR_THRESHOLD,  omsr_pkg::ADDR_RECOG_CTRL: is_writable = 1'b1;
            default:                                              is_writable = 1'b0;
        endcase
    endfunction

    // default value of each writable register
    function automatic logic [7:0] rw_default(input logic [6:0] a);
        case (a)
            omsr_pkg::ADDR_POWER_MODE: rw_default = omsr_pkg::RST_POWER_MODE;
            omsr_pkg::ADDR_SENSOR_CFG: rw_default = omsr_pkg::RST_SENSOR_CFG;
            omsr_pkg::ADDR_WRITE_LOCK: rw_default = omsr_pkg::RST_WRITE_LOCK;
            omsr_pkg::ADDR_LIGHT_CFG:  rw_default = omsr_pkg::RST_LIGHT_CFG;
            omsr_pkg::ADDR_ENTRY_DLY:  rw_default = omsr_pkg::RST_ENTRY_DLY;
            omsr_pkg::ADDR_DEEP_CFG:   rw_default = omsr_pkg::RST_DEEP_CFG;
            omsr_pkg::ADDR_THRESHOLD:  rw_default = omsr_pkg::RST_THRESHOLD;
            omsr_pkg::ADDR_RECOG_CTRL: rw_default = omsr_pkg::RST_RECOG_CTRL;
            default:                   rw_default = 8'h00;
        endcase
    endfunction

    // ---------------- pin synchronisers ----------------
    logic sclk_m_q;      // first stage, read only by sclk_s_q
    logic sclk_s_q;      // synchronised serial clock
    logic sclk_p_q;      // previous value for edge detect
    logic sdio_m_q;      // first stage, read only by sdio_s_q
    logic sdio_s_q;      // synchronised data in
    logic sclk_rise;
    logic sclk_fall;

    // two flops per pin, third flop for edges
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sclk_m_q <= 1'b1;
            sclk_s_q <= 1'b1;
            sclk_p_q <= 1'b1;
            sdio_m_q <= 1'b0;
            sdio_s_q <= 1'b0;
        end else begin
            sclk_m_q <= sclk;
            sclk_s_q <= sclk_m_q;
            sclk_p_q <= sclk_s_q;
            sdio_m_q <= sdio_i;
            sdio_s_q <= sdio_m_q;
        end
    end

    // edges of the host clock
    always_comb begin
        sclk_rise = sclk_s_q & ~sclk_p_q;
        sclk_fall = ~sclk_s_q & sclk_p_q;
    end

    // ---------------- serial port slave ----------------
    omsr_pkg::omsr_ser_t ser_q, ser_d;     // transaction phase
    logic [2:0]          bit_q, bit_d;     // bit within byte
    logic [7:0]          shf_q, shf_d;     // shift register
    logic [6:0]          addr_q, addr_d;   // latched register address
    logic                sdo_q, sdo_d;     // data driven out
    logic                oe_n_q, oe_n_d;   // low while driving
    logic [IDLE_W-1:0]   idle_q, idle_d;   // cycles without a clock edge
    logic                wr_q, wr_d;       // one-cycle write strobe
    logic                rd_q, rd_d;       // one-cycle read strobe
    logic [7:0]          rd_data;          // read multiplexer

    // next state of the serial port
    always_comb begin
        ser_d  = ser_q;
        bit_d  = bit_q;
        shf_d  = shf_q;
        addr_d = addr_q;
        sdo_d  = sdo_q;
        oe_n_d = oe_n_q;
        wr_d   = 1'b0;
        rd_d   = 1'b0;
        idle_d = (sclk_rise | sclk_fall) ? '0 :
                 (idle_q == IDLE_W'(RESYNC_CYC)) ? idle_q : idle_q + 1'b1;
        case (ser_q)
            omsr_pkg::SER_ADDR: begin
                if (sclk_rise) begin
                    shf_d = {shf_q[6:0], sdio_s_q};
                    bit_d = bit_q + 3'd1;
                    if (bit_q == 3'd7) begin
                        addr_d = shf_d[6:0];
                        ser_d  = shf_d[omsr_pkg::SER_RW_BIT] ? omsr_pkg::SER_WDATA
                                                             : omsr_pkg::SER_RLOAD;
                    end
                end
            end
            omsr_pkg::SER_WDATA: begin
                if (sclk_rise) begin
                    shf_d = {shf_q[6:0], sdio_s_q};
                    bit_d = bit_q + 3'd1;
                    if (bit_q == 3'd7) begin
                        wr_d  = 1'b1;
                        ser_d = omsr_pkg::SER_ADDR;
                    end
                end
            end
            omsr_pkg::SER_RLOAD: begin
                shf_d  = rd_data;
                rd_d   = 1'b1;
                oe_n_d = 1'b0;
                ser_d  = omsr_pkg::SER_RDATA;
            end
            omsr_pkg::SER_RDATA: begin
                if (sclk_fall) begin
                    sdo_d = shf_q[7];
                    shf_d = {shf_q[6:0], 1'b0};
                end
                if (sclk_rise) begin
                    bit_d = bit_q + 3'd1;
                    if (bit_q == 3'd7) begin
                        oe_n_d = 1'b1;
                        ser_d  = omsr_pkg::SER_ADDR;
                    end
                end
            end
            default: ser_d = omsr_pkg::SER_ADDR;
        endcase
        // long idle with the clock high: drop any partial frame
        if (idle_q == IDLE_W'(RESYNC_CYC) && sclk_s_q) begin
            ser_d  = omsr_pkg::SER_ADDR;
            bit_d  = 3'd0;
            oe_n_d = 1'b1;
        end
    end

    // serial port registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ser_q  <= omsr_pkg::SER_ADDR;
            bit_q  <= 3'd0;
            shf_q  <= 8'h00;
            addr_q <= 7'h00;
            sdo_q  <= 1'b0;
            oe_n_q <= 1'b1;
            idle_q <= '0;
            wr_q   <= 1'b0;
            rd_q   <= 1'b0;
        end else begin
            ser_q  <= ser_d;
            bit_q  <= bit_d;
            shf_q  <= shf_d;
            addr_q <= addr_d;
            sdo_q  <= sdo_d;
            oe_n_q <= oe_n_d;
            idle_q <= idle_d;
            wr_q   <= wr_d;
            rd_q   <= rd_d;
        end
    end

    // ---------------- writable registers ----------------
    logic [7:0] cfg_q [5:14];   // indexed by address
    logic [7:0] cfg_d [5:14];

    // store host writes to writable addresses only
    always_comb begin
        for (int i = 5; i <= 14; i++) begin
            cfg_d[i] = cfg_q[i];
        end
        if (wr_q && is_writable(addr_q)) begin
            cfg_d[addr_q[3:0]] = shf_q;
        end
    end

    // defaults at reset
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int i = 5; i <= 14; i++) begin
                cfg_q[i] <= rw_default(7'(i));
            end
        end else begin
            for (int i = 5; i <= 14; i++) begin
                cfg_q[i] <= cfg_d[i];
            end
        end
    end

    // ---------------- motion accumulation ----------------
    logic signed [7:0] accx_q, accx_d;   // x displacement since last read
    logic signed [7:0] accy_q, accy_d;   // y displacement since last read
    logic              ovfx_q, ovfx_d;   // x_overflow_flag
    logic              ovfy_q, ovfy_d;   // y_overflow_flag
    logic [7:0]        qual_q, qual_d;   // surface quality
    logic              take;             // usable motion report
    logic              moved;            // motion pending for host
    logic [8:0]        sumx;
    logic [8:0]        sumy;

    // accumulate, saturate, clear on read; new motion beats the clear
    always_comb begin
        take   = motion_valid && (motion_sample.quality >= cfg_q[13])
                 && (motion_sample.dx != 8'sh00 || motion_sample.dy != 8'sh00);
        accx_d = (rd_q && addr_q == omsr_pkg::ADDR_X_DISP) ? 8'sh00 : accx_q;
        ovfx_d = (rd_q && addr_q == omsr_pkg::ADDR_X_DISP) ? 1'b0 : ovfx_q;
        accy_d = (rd_q && addr_q == omsr_pkg::ADDR_Y_DISP) ? 8'sh00 : accy_q;
        ovfy_d = (rd_q && addr_q == omsr_pkg::ADDR_Y_DISP) ? 1'b0 : ovfy_q;
        sumx   = {accx_d[7], accx_d} + {motion_sample.dx[7], motion_sample.dx};
        sumy   = {accy_d[7], accy_d} + {motion_sample.dy[7], motion_sample.dy};
        qual_d = motion_valid ? motion_sample.quality : qual_q;
        if (take) begin
            if (sumx[8] != sumx[7]) begin
                accx_d = sumx[8] ? 8'sh80 : 8'sh7F;
                ovfx_d = 1'b1;
            end else begin
                accx_d = sumx[7:0];
            end
            if (sumy[8] != sumy[7]) begin
                accy_d = sumy[8] ? 8'sh80 : 8'sh7F;
                ovfy_d = 1'b1;
            end else begin
                accy_d = sumy[7:0];
            end
        end
        moved = (accx_q != 8'sh00) || (accy_q != 8'sh00) || ovfx_q || ovfy_q;
    end

    // motion registers, flags clear at reset
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            accx_q <= 8'sh00;
            accy_q <= 8'sh00;
            ovfx_q <= 1'b0;
            ovfy_q <= 1'b0;
            qual_q <= 8'h00;
        end else begin
            accx_q <= accx_d;
            accy_q <= accy_d;
            ovfx_q <= ovfx_d;
            ovfy_q <= ovfy_d;
            qual_q <= qual_d;
        end
    end

    // ---------------- low power timer and sleep ----------------
    omsr_pkg::omsr_pwr_t pwr_q, pwr_d;    // activity state
    logic [LPT_W-1:0]    lpt_q, lpt_d;    // low_power_timer prescaler
    logic [4:0]          tick_q, tick_d;  // idle ticks counted
    logic [WAKE_W-1:0]   wk_q, wk_d;      // wake pulse remaining
    logic                wake_n_q, wake_n_d;
    logic [1:0]          slp_q, slp_d;    // {deep, light} output flops
    logic                lpt_tick;
    logic [4:0]          light_lim;
    logic [4:0]          deep_lim;

    // sleep entry on idle ticks, exit on motion
    always_comb begin
        lpt_tick  = (lpt_q == LPT_W'(LPT_TICK_CYC - 1));
        lpt_d     = lpt_tick ? '0 : lpt_q + 1'b1;
        light_lim = {1'b0, cfg_q[11][omsr_pkg::ENTRY_LIGHT_LSB +: 4]} + 5'd1;
        deep_lim  = {1'b0, cfg_q[11][omsr_pkg::ENTRY_DEEP_LSB +: 4]} + 5'd1;
        pwr_d     = pwr_q;
        tick_d    = (lpt_tick && tick_q != 5'h1F) ? tick_q + 5'd1 : tick_q;
        wk_d      = (wk_q != '0) ? wk_q - 1'b1 : wk_q;
        case (pwr_q)
            omsr_pkg::PWR_NORMAL: begin
                if (take) begin
                    tick_d = 5'd0;
                end else if (cfg_q[5][omsr_pkg::PMODE_LIGHT_BIT] && tick_q >= light_lim) begin
                    pwr_d  = omsr_pkg::PWR_LIGHT;
                    tick_d = 5'd0;
                end
            end
            omsr_pkg::PWR_LIGHT, omsr_pkg::PWR_DEEP: begin
                if (take || !cfg_q[5][omsr_pkg::PMODE_LIGHT_BIT]) begin
                    pwr_d  = omsr_pkg::PWR_NORMAL;
                    tick_d = 5'd0;
                    wk_d   = WAKE_W'(WAKE_CYC);
                end else if (pwr_q == omsr_pkg::PWR_LIGHT && tick_q >= deep_lim
                             && cfg_q[5][omsr_pkg::PMODE_DEEP_BIT]) begin
                    pwr_d  = omsr_pkg::PWR_DEEP;
                    tick_d = 5'd0;
                end
            end
            default: pwr_d = omsr_pkg::PWR_NORMAL;
        endcase
        wake_n_d = ~(moved || wk_q != '0);
        slp_d    = {pwr_d == omsr_pkg::PWR_DEEP, pwr_d == omsr_pkg::PWR_LIGHT};
    end

    // power registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pwr_q    <= omsr_pkg::PWR_NORMAL;
            lpt_q    <= '0;
            tick_q   <= 5'd0;
            wk_q     <= '0;
            wake_n_q <= 1'b1;
            slp_q    <= 2'b00;
        end else begin
            pwr_q    <= pwr_d;
            lpt_q    <= lpt_d;
            tick_q   <= tick_d;
            wk_q     <= wk_d;
            wake_n_q <= wake_n_d;
            slp_q    <= slp_d;
        end
    end

    // ---------------- read multiplexer ----------------
    always_comb begin
        case (addr_q)
            omsr_pkg::ADDR_ID_UPPER:   rd_data = PRODUCT_IDENT[11:4];
            omsr_pkg::ADDR_ID_LOWER:   rd_data = {PRODUCT_IDENT[3:0], RSVD_NIBBLE};
            omsr_pkg::ADDR_MOVE_FLAGS: rd_data = {moved, 2'b00, ovfy_q, ovfx_q,
                                                  cfg_q[6][omsr_pkg::CFG_RES_LSB +: 3]};
            omsr_pkg::ADDR_X_DISP:     rd_data = accx_q;
            omsr_pkg::ADDR_Y_DISP:     rd_data = accy_q;
            omsr_pkg::ADDR_SURF_QUAL:  rd_data = qual_q;
            omsr_pkg::ADDR_ACTIVITY:   rd_data = {6'h00, pwr_q == omsr_pkg::PWR_DEEP,
                                                  pwr_q == omsr_pkg::PWR_LIGHT};
            default:                   rd_data = is_writable(addr_q) ? cfg_q[addr_q[3:0]] : 8'h00;
        endcase
    end

    // outputs, all straight from flops
    always_comb begin
        sdio_o            = sdo_q;
        sdio_oe_n         = oe_n_q;
        wake_motion_n     = wake_n_q;
        resolution_select = cfg_q[6][omsr_pkg::CFG_RES_LSB +: 3];
        recognition_ctrl  = cfg_q[14];
        light_sleep_cfg   = cfg_q[10];
        deep_sleep_cfg    = cfg_q[12];
        light_sleep       = slp_q[0];
        deep_sleep        = slp_q[1];
    end
endmodule // omsr_regs

`default_nettype wire

// ==== verif/omsr_host_model.sv ====
// model: serial port host driving clock and shared data line
`timescale 1ns/1ps
`default_nettype none
module omsr_host_model (
    input  wire logic clock,
    input  wire logic sdio_line,
    output logic      sclk,
    output logic      host_d,
    output logic      host_oe
);
    initial begin
        sclk = 1'b1;  // clock idles high
        host_d = 1'b1;
        host_oe = 1'b0;
    end
    // half of a 48 ns serial period
    task automatic half();
        repeat (6) @(negedge clock);
    endtask
    // one frame: address byte then data byte, msb first
    task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] wd,
                        output logic [7:0] rd);
        logic [15:0] fr;
        fr = {wr, a, wd};
        rd = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            half();
            sclk = 1'b0;  // host owns the clock
            host_oe = wr || i > 7;  // drive only our own bits
            host_d = fr[i];
            half();
            sclk = 1'b1;
            if (!wr && i < 8) rd[i] = sdio_line;
            if (!wr && i == 8) begin
                @(negedge clock);  // let go before the device turns the line
                host_oe = 1'b0;
            end
        end
        half();
        host_oe = 1'b0;
    endtask
    // read address byte only, then stop with the clock high
    task automatic cut(input logic [6:0] a);
        logic [7:0] fr;
        fr = {1'b0, a};
        for (int i = 7; i >= 0; i--) begin
            half();
            sclk = 1'b0;
            host_oe = 1'b1;
            host_d = fr[i];
            half();
            sclk = 1'b1;
        end
        @(negedge clock);  // let go before the device turns the line
        host_oe = 1'b0;
    endtask
endmodule // omsr_host_model
`default_nettype wire

// ==== verif/omsr_regs_assertions.sv ====
// checker: port assertions of the motion sensor register bank
`timescale 1ns/1ps
`default_nettype none
module omsr_regs_checker #(
    parameter int unsigned RESYNC_CYC = 250
) (
    input wire logic                   clock,
    input wire logic                   sys_rst,
    input wire logic                   sclk,
    input wire logic                   sdio_oe_n,
    input wire logic                   wake_motion_n,
    input wire logic                   motion_valid,
    input wire omsr_pkg::omsr_motion_t motion_sample,
    input wire logic [2:0]             resolution_select,
    input wire logic                   light_sleep,
    input wire logic                   deep_sleep
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic [9:0] hi_q;  // cycles with serial clock high
    logic [9:0] hi_d;  // next count
    // count idle-high serial clock, saturating
    always_comb begin
        hi_d = sclk ? hi_q + 10'h001 : 10'h000;
        if (hi_q == 10'h3FF) hi_d = hi_q;
    end
    always_ff @(posedge clock) begin
        hi_q <= sys_rst ? 10'h000 : hi_d;
    end
    // a sample that passes any threshold
    sequence s_taken;
        motion_valid && motion_sample.quality == 8'hFF && motion_sample.dx != 8'h00;
    endsequence
    // wake goes low shortly
    sequence s_wake_soon;
        ##[1:2] !wake_motion_n;
    endsequence
    AST_RST_PINS: assert property ($past(sys_rst) |->
        sdio_oe_n && wake_motion_n && !light_sleep && !deep_sleep) else $error("not idle");
    AST_RST_RES: assert property ($past(sys_rst) |-> resolution_select == 3'h4)
        else $error("resolution not default");
    AST_WAKE_MOTION: assert property (s_taken |-> s_wake_soon)
        else $error("no wake on motion");
    AST_WAKE_EXIT: assert property (!$past(sys_rst) && $fell(light_sleep || deep_sleep)
        |-> ##[0:2] !wake_motion_n) else $error("no wake on sleep exit");
    AST_SLEEP_EXCL: assert property (!(light_sleep && deep_sleep))
        else $error("two sleep states");
    AST_DEEP_VIA_LIGHT: assert property ($rose(deep_sleep) |-> $past(light_sleep))
        else $error("deep sleep skipped light");
    AST_RESYNC_OE: assert property (hi_q > RESYNC_CYC + 10 |-> sdio_oe_n)
        else $error("line held while idle");
    AST_RES_FRAME: assert property (!$past(sys_rst) && $changed(resolution_select)
        |-> sclk) else $error("resolution changed mid frame");
endmodule // omsr_regs_checker
bind omsr_regs omsr_regs_checker #(.RESYNC_CYC(RESYNC_CYC)) omsr_regs_checker_i (
    .clock(clock), .sys_rst(sys_rst), .sclk(sclk), .sdio_oe_n(sdio_oe_n),
    .wake_motion_n(wake_motion_n), .motion_valid(motion_valid),
    .motion_sample(motion_sample), .resolution_select(resolution_select),
    .light_sleep(light_sleep), .deep_sleep(deep_sleep));
`default_nettype wire

// ==== verif/test_optical_motion_sensor_regs.sv ====
// testbench: register bank, motion and sleep checks through the serial port
`timescale 1ns/1ps
`default_nettype none
module test_optical_motion_sensor_regs;
    logic clock = 1'b0, sys_rst = 1'b1, motion_valid = 1'b0;
    omsr_pkg::omsr_motion_t motion_sample = '0;
    wire logic sclk, host_d, host_oe, sdio_line;
    logic sdio_o, sdio_oe_n, wake_motion_n, light_sleep, deep_sleep;
    logic [2:0] res_sel;
    logic [7:0] rec, lcfg, dcfg, rd;
    int n_fail = 0, cmp_count = 0;
    localparam logic [6:0] WA [8] = '{7'h05, 7'h06, 7'h09, 7'h0A, 7'h0B, 7'h0C, 7'h0D, 7'h0E};
    localparam logic [7:0] WD [8] = '{8'hB8, 8'h04, 8'h00, 8'h72, 8'h12, 8'h92, 8'h0A, 8'hE5};
    // line has a pull-up when nobody drives
    assign sdio_line = !sdio_oe_n ? sdio_o : (host_oe ? host_d : 1'b1);
    always #2 clock = ~clock;
    omsr_regs #(.LPT_TICK_CYC(20), .WAKE_CYC(8)) omsr_regs_i (
        .clock(clock), .sys_rst(sys_rst), .sclk(sclk), .sdio_i(sdio_line),
        .sdio_o(sdio_o), .sdio_oe_n(sdio_oe_n), .wake_motion_n(wake_motion_n),
        .motion_valid(motion_valid), .motion_sample(motion_sample),
        .resolution_select(res_sel), .recognition_ctrl(rec), .light_sleep_cfg(lcfg),
        .deep_sleep_cfg(dcfg), .light_sleep(light_sleep), .deep_sleep(deep_sleep));
    omsr_host_model omsr_host_model_i (.clock(clock), .sdio_line(sdio_line), .sclk(sclk),
        .host_d(host_d), .host_oe(host_oe));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rreg(input logic [6:0] a, input logic [7:0] exp);
        omsr_host_model_i.xfer(1'b0, a, 8'h00, rd);
        chk(rd, exp);
    endtask
    task automatic wreg(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] unused;
        omsr_host_model_i.xfer(1'b1, a, d, unused);
    endtask
    // one engine report, one cycle wide
    task automatic send(input logic [7:0] dx, input logic [7:0] dy, input logic [7:0] q);
        @(negedge clock);
        motion_valid = 1'b1;
        motion_sample = {dx, dy, q};
        @(negedge clock);
        motion_valid = 1'b0;
    endtask
    task automatic t_reset();
        rreg(7'h00, 8'hA5);
        omsr_host_model_i.xfer(1'b0, 7'h01, 8'h00, rd);
        chk({rd[7:4], 4'h0}, 8'hC0);
        for (int i = 0; i < 8; i++) rreg(WA[i], WD[i]);
        chk({5'h00, res_sel}, 8'h04);
        chk(rec, 8'hE5);
        chk(lcfg, 8'h72);
        chk(dcfg, 8'h92);
        rreg(7'h20, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_write();
        for (int i = 0; i < 8; i++) begin
            wreg(WA[i], ~WD[i]);
            rreg(WA[i], ~WD[i]);
            wreg(WA[i], WD[i]);
        end
        wreg(7'h00, 8'h00);
        rreg(7'h00, 8'hA5);
        wreg(7'h03, 8'h55);
        rreg(7'h03, 8'h00);
        for (int r = 0; r < 7; r++) begin
            wreg(7'h06, {5'h00, r[2:0]});
            chk({5'h00, res_sel}, {5'h00, r[2:0]});
            rreg(7'h02, {5'h00, r[2:0]});
        end
        wreg(7'h06, 8'h04);
        $display("test write done");
    endtask
    task automatic t_motion();
        send(8'h05, 8'h00, 8'h05);
        rreg(7'h03, 8'h00);
        send(8'h64, 8'hFD, 8'hFF);
        repeat (2) @(negedge clock);
        chk({7'h00, wake_motion_n}, 8'h00);
        send(8'h64, 8'hFD, 8'hFF);
        rreg(7'h02, 8'h8C);
        rreg(7'h03, 8'h7F);
        rreg(7'h04, 8'hFA);
        rreg(7'h07, 8'hFF);
        rreg(7'h02, 8'h04);
        $display("test motion done");
    endtask
    task automatic t_sleep();
        send(8'h01, 8'h01, 8'hFF);
        repeat (3) @(negedge clock);
        chk({6'h00, deep_sleep, light_sleep}, 8'h00);
        for (int k = 0; k < 2000 && light_sleep !== 1'b1; k++) @(negedge clock);
        chk({6'h00, deep_sleep, light_sleep}, 8'h01);
        for (int k = 0; k < 2000 && deep_sleep !== 1'b1; k++) @(negedge clock);
        chk({6'h00, deep_sleep, light_sleep}, 8'h02);
        rreg(7'h08, 8'h02);
        send(8'h01, 8'h01, 8'hFF);
        repeat (3) @(negedge clock);
        chk({5'h00, wake_motion_n, deep_sleep, light_sleep}, 8'h00);
        rreg(7'h03, 8'h02);
        rreg(7'h04, 8'h02);
        for (int k = 0; k < 2000 && !(light_sleep || deep_sleep); k++) @(negedge clock);
        chk({7'h00, light_sleep || deep_sleep}, 8'h01);
        wreg(7'h05, 8'h00);
        chk({7'h00, wake_motion_n}, 8'h00);
        repeat (10) @(negedge clock);
        chk({7'h00, wake_motion_n}, 8'h01);
        repeat (300) @(negedge clock);
        chk({6'h00, deep_sleep, light_sleep}, 8'h00);
        $display("test sleep done");
    endtask
    task automatic t_rerst();
        wreg(7'h0D, 8'h33);
        sys_rst = 1'b1;
        repeat (4) @(negedge clock);
        sys_rst = 1'b0;
        repeat (4) @(negedge clock);
        rreg(7'h0D, 8'h0A);
        rreg(7'h05, 8'hB8);
        $display("test second reset done");
    endtask
    task automatic t_cut();
        omsr_host_model_i.cut(7'h00);
        repeat (8) @(negedge clock);
        chk({7'h00, sdio_oe_n}, 8'h00);
        repeat (300) @(negedge clock);
        chk({7'h00, sdio_oe_n}, 8'h01);
        rreg(7'h00, 8'hA5);
        $display("test cut frame done");
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clock);
        sys_rst = 1'b0;
        repeat (4) @(negedge clock);
        t_reset();
        t_write();
        t_motion();
        t_sleep();
        t_cut();
        t_rerst();
        end_sim();
    end
    // watchdog, well past the expected run
    initial begin
        #300000;
        n_fail++;
        end_sim();
    end
endmodule // test_optical_motion_sensor_regs
`default_nettype wire
